//--- shared/fwp_pkg.sv
// constants for the flash write-protection and status block
// assumes a 50 MHz system clock and a mode-0 serial link with its own clock
package fwp_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 50;
  localparam int SR_WRITE_US  = 10;
  localparam int SR_WRITE_CYC = SR_WRITE_US * CLK_MHZ;

  // ==========================================================
  // instruction codes
  localparam logic [7:0] OPC_WREN    = 8'h06;
  localparam logic [7:0] OPC_WRDI    = 8'h04;
  localparam logic [7:0] OPC_RDSR1   = 8'h05;
  localparam logic [7:0] OPC_RDSR2   = 8'h35;
  localparam logic [7:0] OPC_RDSR3   = 8'h15;
  localparam logic [7:0] OPC_WRSR1   = 8'h01;
  localparam logic [7:0] OPC_WRSR2   = 8'h31;
  localparam logic [7:0] OPC_WRSR3   = 8'h11;
  localparam logic [7:0] OPC_PROG    = 8'h12;
  localparam logic [7:0] OPC_SECT_ER = 8'h21;
  localparam logic [7:0] OPC_BLK_ER  = 8'hdc;
  localparam logic [7:0] OPC_CHIP_ER = 8'hc7;
  localparam logic [7:0] OPC_SEC_ER  = 8'h44;
  localparam logic [7:0] OPC_SEC_PG  = 8'h42;
  localparam logic [7:0] OPC_UNLOCK  = 8'h39;
  localparam logic [7:0] OPC_LOCK    = 8'h36;
  localparam logic [7:0] OPC_PDOWN   = 8'hb9;
  localparam logic [7:0] OPC_RELEASE = 8'hab;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME  = 8'h7a;
  localparam logic [7:0] OPC_FREAD   = 8'h0c;

  // ==========================================================
  // status field positions
  localparam int ST1_BUSY  = 0;
  localparam int ST1_WEL   = 1;
  localparam int ST1_BP_LO = 2;
  localparam int ST1_TB    = 6;
  localparam int ST1_SRP   = 7;
  localparam int ST2_SRL   = 0;
  localparam int ST2_QE    = 1;
  localparam int ST2_CMP   = 6;
  localparam int ST2_SUS   = 7;
  localparam int ST3_WPS   = 2;
  localparam int BP_W      = 4;

  // ==========================================================
  // array organisation
  localparam int         NUM_DIES      = 4;
  localparam int         NUM_BLK_LOCKS = 4088;
  localparam int         NUM_SEC_LOCKS = 128;
  localparam int         SEC_PER_BLK   = 16;
  localparam int         ADDR_W        = 28;
  localparam int         DIE_LSB       = 26;
  localparam int         HALF_MSB      = 26;
  localparam int         BLK_LSB       = 16;
  localparam int         SEC_LSB       = 12;
  localparam logic [9:0] DIE_BLK_LAST  = 10'h3ff;
  localparam logic [11:0] LOCKED_PER_DIE = 12'h3fe;
  localparam logic [11:0] HALF_BLKS    = 12'h800;
  localparam logic [3:0]  BP_ALL       = 4'hc;

  // ==========================================================
  // frame layout
  localparam logic [3:0] NB_ADDR_DONE = 4'h5;
  localparam logic [3:0] NB_LAST_ADDR = 4'h4;
  localparam logic [3:0] NB_SR_ONE    = 4'h2;
  localparam logic [3:0] NB_SR_TWO    = 4'h3;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [2:0] {
    FWP_OP_PROG, FWP_OP_SECT_ER, FWP_OP_BLK_ER, FWP_OP_CHIP_ER,
    FWP_OP_SEC_ER, FWP_OP_SEC_PG, FWP_OP_SUSPEND, FWP_OP_RESUME
  } fwp_op_t;

endpackage

//--- hw/fwp_sync.sv
// two-flop level synchroniser
// assumes d is a level from another clock domain or a pin
`timescale 1ns/1ns
`default_nettype none
module fwp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- hw/fwp_top.sv
// write protection, status registers and busy tracking of a four-die flash
// assumes sclk toggles only while cs_n is low; array answers op_done per die
// What this block does
// - supply below threshold holds the system-clock logic in reset (the sclk side runs on), no instruction taken
// - after supply good, write-type instructions refused for a set delay
// - power-up leaves the write-enable latch cleared
// - program, erase and status write need the write-enable latch set
// - completion of program, erase or status write clears the latch
// - latch set by write enable, cleared by write disable and writes
// - in power-down only the release instruction, status reads and fast reads are obeyed
// - lock bits for 4088 blocks and 128 edge-block sectors
// - locked region ignores program and erase, unlocked proceeds
// - all lock bits set at power-on; unlock clears one region
// - scheme select picks block-protect fields or per-region locks
// - continuous read wraps to start of the same die
// - addressless register writes go to all dies when none busy
// - status read shows per-die busy and suspend, shared other fields
// - busy flag high during program, erase, status write; low after
// - while the addressed die (any die, for addressless ones) is busy only status read, fast read and suspend are accepted
// - four block-protect bits set protected size; zero protects nothing
// - top/bottom bit counts protection from top (0) or bottom (1)
// - complement bit inverts the protected region
// - protect and lock bits zero: status writable whenever latch set
// - protect bit set, lock clear: write-protect pin low refuses writes
// - lock bit set blocks status writes until next power cycle
// - quad enable turns off write-protect pin checking
`timescale 1ns/1ns
`default_nettype none
module fwp_top #(
  parameter int PUW_US = 5000
) (
  // system clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // supply monitor
  input  wire logic            supply_ok,
  // serial link
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            mosi,
  output logic                 miso,
  output logic                 miso_oe,
  input  wire logic            wp_n,
  // array controller
  output logic                 op_start,
  output fwp_pkg::fwp_op_t     op_kind,
  output logic [27:0]          op_addr,
  input  wire logic [3:0]      op_done,
  output logic [27:0]          rd_addr,
  input  wire logic [7:0]      rd_data
);
  import fwp_pkg::*;

  localparam int PUW_CYC = PUW_US * CLK_MHZ;

  // ==========================================================
  // link side, on sclk
  logic [2:0]  bit_cnt_r;
  logic        fresh_r;
  logic        got_r;
  logic        snd_r;
  logic [6:0]  sh_r;
  logic [7:0]  opc_r;
  logic [7:0]  b1_r;
  logic [7:0]  b2_r;
  logic [31:0] adr_r;
  logic [3:0]  nbyte_r;
  logic [7:0]  tx_r;
  logic [27:0] rd_addr_r;
  logic        miso_r;
  logic        miso_oe_r;
  logic [7:0]  st1_pub_r;
  logic [7:0]  st2_pub_r;
  logic [7:0]  st3_pub_r;
  wire  [7:0]  byte_in  = {sh_r, mosi};
  wire         byte_end = (bit_cnt_r == BIT_LAST);
  wire  [7:0]  cur_op   = fresh_r ? opc_r : byte_in;
  wire         is_rdsr  = (cur_op == OPC_RDSR1) || (cur_op == OPC_RDSR2) ||
                          (cur_op == OPC_RDSR3);
  logic [7:0]  st_sel;

  always_comb begin
    st_sel = st3_pub_r;
    if (cur_op == OPC_RDSR1) begin
      st_sel = st1_pub_r;
    end else if (cur_op == OPC_RDSR2) begin
      st_sel = st2_pub_r;
    end
  end

  // cs_n high restarts the frame; captured bytes stay for the system side
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= '0;
      fresh_r   <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_end) begin
        fresh_r <= 1'b1;
      end
    end
  end

  // survives cs_n high so the system side still sees a whole byte came in
  always_ff @(posedge sclk) begin
    if (byte_end) begin
      got_r <= 1'b1;
    end else if (bit_cnt_r == '0 && !fresh_r) begin
      got_r <= 1'b0;
    end
  end

  always_ff @(posedge sclk) begin
    sh_r <= byte_in[6:0];
    if (byte_end) begin
      if (!fresh_r) begin
        opc_r   <= byte_in;
        nbyte_r <= 4'h1;
      end else if (nbyte_r != 4'hf) begin
        nbyte_r <= nbyte_r + 4'h1;
      end
      if (fresh_r && nbyte_r == 4'h1) begin
        b1_r <= byte_in;
      end
      if (fresh_r && nbyte_r == NB_SR_ONE) begin
        b2_r <= byte_in;
      end
      if (fresh_r && nbyte_r < NB_ADDR_DONE) begin
        adr_r <= {adr_r[23:0], byte_in};
      end
    end
  end

  // status bytes repeat; read data streams one byte behind its address
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_r      <= '0;
      snd_r     <= 1'b0;
      rd_addr_r <= '0;
    end else if (byte_end && is_rdsr) begin
      tx_r  <= st_sel;
      snd_r <= 1'b1;
    end else if (byte_end && fresh_r && opc_r == OPC_FREAD) begin
      if (nbyte_r == NB_LAST_ADDR) begin
        rd_addr_r <= {adr_r[19:0], byte_in};
      end else if (nbyte_r >= NB_ADDR_DONE) begin
        tx_r      <= rd_data;
        snd_r     <= 1'b1;
        rd_addr_r <= {rd_addr_r[ADDR_W-1:DIE_LSB],
                      DIE_LSB'(rd_addr_r[DIE_LSB-1:0] + 26'h0000001)};
      end
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_r    <= tx_r[7];
      miso_oe_r <= snd_r;
    end
  end

  assign miso    = miso_r;
  assign miso_oe = miso_oe_r;
  assign rd_addr = rd_addr_r;

  // ==========================================================
  // crossings and power
  logic pwr_s;
  logic cs_s;
  logic wp_s;
  logic cs_d_r;
  logic rst_int;

  fwp_sync #(.RST_VAL(1'b0)) u_sync_pwr (
    .clk (clk_sys), .rst (rst), .d (supply_ok), .q (pwr_s));
  fwp_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk (clk_sys), .rst (rst), .d (cs_n), .q (cs_s));
  fwp_sync #(.RST_VAL(1'b1)) u_sync_wp (
    .clk (clk_sys), .rst (rst), .d (wp_n), .q (wp_s));

  assign rst_int = rst || !pwr_s;

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      cs_d_r <= 1'b1;
    end else begin
      cs_d_r <= cs_s;
    end
  end

  // frame registers are quiet once cs_n is high, so they are read directly
  wire take = cs_s && !cs_d_r && got_r;

  logic [23:0] puw_cnt_r;
  logic        puw_done_r;
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      puw_cnt_r  <= '0;
      puw_done_r <= 1'b0;
    end else if (!puw_done_r) begin
      puw_cnt_r <= puw_cnt_r + 24'h000001;
      if (puw_cnt_r == 24'(PUW_CYC - 1)) begin
        puw_done_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // decode
  logic [3:0]           busy_r;
  logic [3:0]           sus_r;
  logic                 wel_r;
  logic                 pd_r;
  logic [BP_W-1:0]      bp_r;
  logic                 tb_r;
  logic                 srp_r;
  logic                 srl_r;
  logic                 qe_r;
  logic                 cmp_r;
  logic                 wps_r;
  logic [NUM_BLK_LOCKS-1:0] lock_blk_r;
  logic [NUM_SEC_LOCKS-1:0] lock_sec_r;

  wire [7:0]  op     = opc_r;
  wire [27:0] fa     = adr_r[ADDR_W-1:0];
  wire [1:0]  fdie   = fa[ADDR_W-1:DIE_LSB];
  wire [9:0]  dblk   = fa[DIE_LSB-1:BLK_LSB];
  wire        edge_b = (dblk == '0) || (dblk == DIE_BLK_LAST);
  wire [11:0] bidx   = 12'(12'(fdie) * LOCKED_PER_DIE + 12'(dblk) - 12'h001);
  wire [6:0]  sidx   = {fdie, dblk[9], fa[BLK_LSB-1:SEC_LSB]};
  wire [6:0]  sgrp   = {fdie, dblk[9], 4'h0};
  wire        is_sec = (op == OPC_SEC_ER) || (op == OPC_SEC_PG);
  wire        is_pe  = (op == OPC_PROG) || (op == OPC_SECT_ER) ||
                       (op == OPC_BLK_ER) || (op == OPC_CHIP_ER) || is_sec;
  wire        is_lk  = (op == OPC_UNLOCK) || (op == OPC_LOCK);
  wire        is_adr = (is_pe && op != OPC_CHIP_ER) || is_lk;
  wire        is_wrsr = (op == OPC_WRSR1) || (op == OPC_WRSR2) ||
                        (op == OPC_WRSR3);
  wire        adr_ok = (nbyte_r >= NB_ADDR_DONE);
  wire        busy_hit = is_adr ? busy_r[fdie] : (|busy_r);
  wire        pd_hit = pd_r && (op != OPC_RELEASE);
  wire        go     = take && !pd_hit &&
                       (!busy_hit || op == OPC_SUSPEND);
  wire        wel_ok = wel_r && puw_done_r;

  // block-protect fields, applied per 1Gbit half
  logic [11:0] span;
  logic        in_rng;
  logic        bp_hit;
  logic        lock_hit;
  logic        prot;
  always_comb begin
    span   = 12'h001 << (bp_r - 4'h1);
    in_rng = tb_r ? ({1'b0, fa[HALF_MSB:BLK_LSB]} < span)
                  : ({1'b0, fa[HALF_MSB:BLK_LSB]} >= (HALF_BLKS - span));
    bp_hit = ((bp_r == '0) ? 1'b0 : (bp_r >= BP_ALL) ? 1'b1 : in_rng)
             ^ cmp_r;
    if (edge_b && op == OPC_BLK_ER) begin
      lock_hit = |lock_sec_r[sgrp +: SEC_PER_BLK];
    end else if (edge_b) begin
      lock_hit = lock_sec_r[sidx];
    end else begin
      lock_hit = lock_blk_r[bidx];
    end
    if (is_sec) begin
      prot = 1'b0;
    end else if (op == OPC_CHIP_ER) begin
      prot = wps_r ? ((|lock_blk_r) || (|lock_sec_r))
                   : ((bp_r != '0) || cmp_r);
    end else begin
      prot = wps_r ? lock_hit : bp_hit;
    end
  end

  wire pe_ok   = go && is_pe && wel_ok && (adr_ok || op == OPC_CHIP_ER) &&
                 !prot;
  wire hw_lock = srp_r && !qe_r && !wp_s;
  wire wrsr_ok = go && is_wrsr && wel_ok && !srl_r && !hw_lock &&
                 nbyte_r >= NB_SR_ONE;
  wire lk_ok   = go && is_lk && wel_ok && adr_ok;
  wire susp_ok = go && op == OPC_SUSPEND && (|busy_r);
  wire res_ok  = go && op == OPC_RESUME && (|sus_r);
  wire done_hit = |(op_done & busy_r);

  // ==========================================================
  // status write timer
  logic [9:0] sr_cnt_r;
  logic       sr_act_r;
  wire        sr_fin = sr_act_r && (sr_cnt_r == 10'(SR_WRITE_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      sr_cnt_r <= '0;
      sr_act_r <= 1'b0;
    end else if (wrsr_ok) begin
      sr_cnt_r <= '0;
      sr_act_r <= 1'b1;
    end else if (sr_fin) begin
      sr_act_r <= 1'b0;
    end else if (sr_act_r) begin
      sr_cnt_r <= sr_cnt_r + 10'h001;
    end
  end

  // ==========================================================
  // busy and suspend per die
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      busy_r <= '0;
      sus_r  <= '0;
    end else if (pe_ok) begin
      busy_r <= (busy_r & ~op_done) |
                ((op == OPC_CHIP_ER) ? 4'hf : (4'h1 << fdie));
    end else if (susp_ok) begin
      sus_r  <= busy_r & ~op_done;
      busy_r <= '0;
    end else if (res_ok) begin
      busy_r <= sus_r;
      sus_r  <= '0;
    end else if (wrsr_ok) begin
      busy_r <= 4'hf;
    end else if (sr_fin) begin
      busy_r <= '0;
    end else begin
      busy_r <= busy_r & ~op_done;
    end
  end

  // ==========================================================
  // write-enable latch
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      wel_r <= 1'b0;
    end else if (go && op == OPC_WREN && puw_done_r) begin
      wel_r <= 1'b1;
    end else if ((go && op == OPC_WRDI) || lk_ok) begin
      wel_r <= 1'b0;
    end else if (done_hit || sr_fin) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      pd_r <= 1'b0;
    end else if (go && op == OPC_PDOWN) begin
      pd_r <= 1'b1;
    end else if (go && op == OPC_RELEASE) begin
      pd_r <= 1'b0;
    end
  end

  // ==========================================================
  // status fields, shared by all dies
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      bp_r  <= '0;
      tb_r  <= 1'b0;
      srp_r <= 1'b0;
      srl_r <= 1'b0;
      qe_r  <= 1'b0;
      cmp_r <= 1'b0;
      wps_r <= 1'b0;
    end else if (wrsr_ok && op == OPC_WRSR3) begin
      wps_r <= b1_r[ST3_WPS];
    end else if (wrsr_ok) begin
      if (op == OPC_WRSR1) begin
        bp_r  <= b1_r[ST1_BP_LO +: BP_W];
        tb_r  <= b1_r[ST1_TB];
        srp_r <= b1_r[ST1_SRP];
      end
      if (op == OPC_WRSR2 || nbyte_r >= NB_SR_TWO) begin
        srl_r <= (op == OPC_WRSR2) ? b1_r[ST2_SRL] : b2_r[ST2_SRL];
        qe_r  <= (op == OPC_WRSR2) ? b1_r[ST2_QE]  : b2_r[ST2_QE];
        cmp_r <= (op == OPC_WRSR2) ? b1_r[ST2_CMP] : b2_r[ST2_CMP];
      end
    end
  end

  // ==========================================================
  // individual locks
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      lock_blk_r <= '1;
      lock_sec_r <= '1;
    end else if (lk_ok && edge_b) begin
      lock_sec_r[sidx] <= (op == OPC_LOCK);
    end else if (lk_ok) begin
      lock_blk_r[bidx] <= (op == OPC_LOCK);
    end
  end

  // ==========================================================
  // array requests
  logic    op_start_r;
  fwp_op_t op_kind_r;
  fwp_op_t kind_nxt;
  logic [27:0] op_addr_r;
  always_comb begin
    kind_nxt = FWP_OP_PROG;
    if (susp_ok) begin
      kind_nxt = FWP_OP_SUSPEND;
    end else if (res_ok) begin
      kind_nxt = FWP_OP_RESUME;
    end else if (op == OPC_SECT_ER) begin
      kind_nxt = FWP_OP_SECT_ER;
    end else if (op == OPC_BLK_ER) begin
      kind_nxt = FWP_OP_BLK_ER;
    end else if (op == OPC_CHIP_ER) begin
      kind_nxt = FWP_OP_CHIP_ER;
    end else if (op == OPC_SEC_ER) begin
      kind_nxt = FWP_OP_SEC_ER;
    end else if (op == OPC_SEC_PG) begin
      kind_nxt = FWP_OP_SEC_PG;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      op_start_r <= 1'b0;
      op_kind_r  <= FWP_OP_PROG;
      op_addr_r  <= '0;
    end else begin
      op_start_r <= pe_ok || susp_ok || res_ok;
      if (pe_ok || susp_ok || res_ok) begin
        op_kind_r <= kind_nxt;
        op_addr_r <= fa;
      end
    end
  end

  assign op_start = op_start_r;
  assign op_kind  = op_kind_r;
  assign op_addr  = op_addr_r;

  // ==========================================================
  // published status; frozen while a frame runs, so it may lag by a frame
  logic [1:0] st_die_r;
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      st_die_r  <= '0;
      st1_pub_r <= '0;
      st2_pub_r <= '0;
      st3_pub_r <= '0;
    end else begin
      if (take && is_adr && adr_ok) begin
        st_die_r <= fdie;
      end
      if (cs_s) begin
        st1_pub_r                      <= '0;
        st1_pub_r[ST1_BUSY]            <= busy_r[st_die_r];
        st1_pub_r[ST1_WEL]             <= wel_r;
        st1_pub_r[ST1_BP_LO +: BP_W]   <= bp_r;
        st1_pub_r[ST1_TB]              <= tb_r;
        st1_pub_r[ST1_SRP]             <= srp_r;
        st2_pub_r                      <= '0;
        st2_pub_r[ST2_SRL]             <= srl_r;
        st2_pub_r[ST2_QE]              <= qe_r;
        st2_pub_r[ST2_CMP]             <= cmp_r;
        st2_pub_r[ST2_SUS]             <= sus_r[st_die_r];
        st3_pub_r                      <= '0;
        st3_pub_r[ST3_WPS]             <= wps_r;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst_int);

  sequence seq_wrsr_take;
    take && is_wrsr;
  endsequence

  chk_wel_power_up: assert property ($fell(rst_int) |-> !wel_r && !puw_done_r)
    else $error("write latch not clear after power up");
  chk_puw_blocks_wren: assert property (
    (take && op == OPC_WREN && !puw_done_r && !wel_r) |=> !wel_r)
    else $error("write enable taken during power-up delay");
  chk_start_needs_wel: assert property ((op_start_r && op_kind_r inside
    {FWP_OP_PROG, FWP_OP_SECT_ER, FWP_OP_CHIP_ER}) |-> $past(wel_r))
    else $error("program or erase started without write latch");
  chk_done_clears_wel: assert property (done_hit |=> !wel_r)
    else $error("write latch kept after completion");
  chk_pdown_ignores: assert property ((pd_r && take && op != OPC_RELEASE)
    |=> !op_start_r && $stable(wel_r))
    else $error("instruction obeyed in power down");
  chk_locks_power_on: assert property ($fell(rst_int)
    |-> (&lock_blk_r) && (&lock_sec_r))
    else $error("lock bits not all set at power on");
  chk_start_sets_busy: assert property ((op_start_r &&
    op_kind_r != FWP_OP_SUSPEND) |-> busy_r != '0)
    else $error("busy not set for started operation");
  chk_srl_locks_down: assert property ((seq_wrsr_take ##0 srl_r)
    |=> $stable(bp_r) && $stable(srl_r) && !sr_act_r)
    else $error("status written while locked down");
  chk_pin_protects: assert property ((seq_wrsr_take ##0 (srp_r && !srl_r &&
    !qe_r && !wp_s)) |=> $stable(bp_r) && !sr_act_r)
    else $error("status written with protect pin low");
  chk_refused_quiet: assert property ((take && is_pe && prot)
    |=> !op_start_r && busy_r == $past(busy_r & ~op_done))
    else $error("refused program or erase went ahead");
  chk_sr_busy_time: assert property ((wrsr_ok ##1 1'b1) |-> busy_r == 4'hf
    ##[1:600] (busy_r == '0))
    else $error("status write busy window wrong");

  property prop_die_wrap;
    @(posedge sclk) disable iff (cs_n)
      ($past(rd_addr_r[DIE_LSB-1:0]) == 26'h3ffffff &&
       rd_addr_r != $past(rd_addr_r))
      |-> rd_addr_r == {$past(rd_addr_r[ADDR_W-1:DIE_LSB]), 26'h0000000};
  endproperty
  chk_read_die_wrap: assert property (prop_die_wrap)
    else $error("continuous read left its die");
endmodule
`default_nettype wire

//--- testbench/fwp_host.sv
// serial host model: mode 0 frames, msb first
// assumes the device shifts miso on falling link edges
`timescale 1ns/1ns
`default_nettype none
module fwp_host (
  // link
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ====
  // link clock runs only inside a frame
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic xfer(input logic [63:0] d, input int n,
                      output logic [7:0] r);
    r = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      mosi = d[63 - i];
      #24 sclk = 1'b1;
      r = {r[6:0], miso};
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the write-protection block
// assumes the host model fwp_host drives the link
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fwp_pkg::*;
  logic        clk_sys, rst, supply_ok, wp_n, sclk, cs_n, mosi, miso, oe;
  logic        op_start;
  logic [3:0]  op_done;
  logic [27:0] op_addr, rd_addr, a, la;
  logic [7:0]  rd_data, rb;
  logic [31:0] seed = 32'h00012fd0;
  fwp_op_t     op_kind, lk;
  int          miscompares = 0, n_tests = 0, n_st = 0, n0, n_oe = 0, n1;
  function automatic logic [7:0] arr(input logic [27:0] x);
    return x[7:0] ^ x[27:20] ^ 8'h5a;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  fwp_top #(.PUW_US(2)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .supply_ok(supply_ok), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(oe), .wp_n(wp_n), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .op_done(op_done),
    .rd_addr(rd_addr), .rd_data(rd_data));
  fwp_host host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // array data tied to address so a wrong wrap shows
  assign rd_data = arr(rd_addr);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge sclk) begin
    if (oe === 1'b1) n_oe++;
  end
  always @(negedge clk_sys) begin
    if (op_start === 1'b1) begin
      n_st++;
      lk = op_kind;
      la = op_addr;
    end
  end
  // ====
  // helpers
  task automatic f(input logic [63:0] d, input int n);
    host_u.xfer(d, n, rb);
  endtask
  task automatic ck(input logic [27:0] g, input logic [27:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic st(input logic [7:0] e);
    f({OPC_RDSR1, 56'h0}, 2);
    ck({20'h0, rb}, {20'h0, e});
  endtask
  task automatic wsr(input logic [7:0] c, input logic [7:0] v);
    f({OPC_WREN, 56'h0}, 1);
    f({c, v, 48'h0}, 2);
    repeat (520) @(negedge clk_sys);
  endtask
  task automatic er(input logic [27:0] x);
    n0 = n_st;
    f({OPC_WREN, 56'h0}, 1);
    f({OPC_SECT_ER, 4'h0, x, 24'h0}, 5);
  endtask
  task automatic done(input logic [27:0] x);
    @(negedge clk_sys) op_done[x[27:26]] = 1'b1;
    @(negedge clk_sys) op_done = 4'h0;
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====
  // watchdog: whole run needs about 7000 cycles
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {rst, supply_ok, wp_n, op_done} = 7'h70;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    f({OPC_WREN, 56'h0}, 1);
    st(8'h00);
    repeat (150) @(negedge clk_sys);
    n0 = n_st;
    f({OPC_SECT_ER, 56'h0}, 5);
    ck(28'(n_st - n0), 28'h0);
    f({OPC_WREN, 56'h0}, 1);
    st(8'h02);
    f({OPC_WRDI, 56'h0}, 1);
    st(8'h00);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a = seed[27:0];
      er(a);
      ck(28'(n_st - n0), 28'h1);
      ck({25'h0, lk}, {25'h0, FWP_OP_SECT_ER});
      ck(la, a);
      f({OPC_WRDI, 56'h0}, 1);
      st(8'h03);
      done(a);
      st(8'h00);
    end
    wsr(OPC_WRSR1, 8'h30);
    st(8'h30);
    er(a);
    ck(28'(n_st - n0), 28'h0);
    st(8'h32);
    wsr(OPC_WRSR1, 8'h80);
    wp_n = 1'b0;
    wsr(OPC_WRSR1, 8'h30);
    st(8'h82);
    wp_n = 1'b1;
    wsr(OPC_WRSR1, 8'h00);
    st(8'h00);
    wsr(OPC_WRSR3, 8'h04);
    a = 28'h0120000;
    er(a);
    ck(28'(n_st - n0), 28'h0);
    f({OPC_UNLOCK, 4'h0, a, 24'h0}, 5);
    er(a);
    ck(28'(n_st - n0), 28'h1);
    done(a);
    n1 = n_oe;
    f({OPC_FREAD, 32'h03ffffff, 24'h0}, 8);
    ck({20'h0, rb}, {20'h0, arr(28'h0)});
    ck(28'(n_oe - n1), 28'h10);
    f({OPC_PDOWN, 56'h0}, 1);
    f({OPC_WREN, 56'h0}, 1);
    f({OPC_RELEASE, 56'h0}, 1);
    st(8'h00);
    wsr(OPC_WRSR2, 8'h01);
    wsr(OPC_WRSR1, 8'h30);
    st(8'h02);
    supply_ok = 1'b0;
    repeat (5) @(negedge clk_sys);
    supply_ok = 1'b1;
    repeat (150) @(negedge clk_sys);
    st(8'h00);
    f({OPC_RDSR2, 56'h0}, 2);
    ck({20'h0, rb}, 28'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
